/* File: verilog/ppm_pkg.sv */
// Package for the port pad mode control block: register map and layouts
package ppm_pkg;
    // Register indices on the plain register port (word per register)
    localparam logic [3:0] ADDR_OD_PORT_TWO   = 4'h0;
    localparam logic [3:0] ADDR_OD_PORT_THREE = 4'h1;
    localparam logic [3:0] ADDR_OD_PORT_FOUR  = 4'h2;
    localparam logic [3:0] ADDR_OD_PORT_SIX   = 4'h3;
    localparam logic [3:0] ADDR_OD_PORT_SEVEN = 4'h4;
    localparam logic [3:0] ADDR_OD_PORT_EIGHT = 4'h5;
    localparam logic [3:0] ADDR_THR           = 4'h6;
    localparam logic [3:0] ADDR_SPACE         = 4'h7;
    // Port widths
    localparam int W2 = 16;
    localparam int W3 = 16;
    localparam int W4 = 8;
    localparam int W6 = 8;
    localparam int W7 = 8;
    localparam int W8 = 8;
    // First pin of each port in the packed pin vectors
    localparam int BASE_TWO   = 0;
    localparam int BASE_THREE = 16;
    localparam int BASE_FOUR  = 32;
    localparam int BASE_SIX   = 40;
    localparam int BASE_SEVEN = 48;
    localparam int BASE_EIGHT = 56;
    // Threshold register field positions
    localparam int THR_P2L = 0;
    localparam int THR_P2H = 1;
    localparam int THR_P3L = 2;
    localparam int THR_P3H = 3;
    localparam int THR_P7L = 4;
    localparam int THR_P8L = 5;
    localparam int THR_W   = 6;
    // Reset values
    localparam logic [15:0]      OD_RST  = 16'h0000;
    localparam logic [THR_W-1:0] THR_RST = 6'h00;
    // One pad's drive request and resulting driver controls
    typedef struct packed {
        logic out_val;
        logic dir_out;
        logic od_sel;
    } ppm_req_t;
    typedef struct packed {
        logic pull_up_on;
        logic pull_dn_on;
        logic oe;
    } ppm_drv_t;
endpackage

/* File: verilog/ppm_pad_ctrl.sv */
// One pad line: push/pull or open-drain driver decode, registered
`timescale 1ns/10ps
module ppm_pad_ctrl
(
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rstn,
    // Request
    input  wire ppm_pkg::ppm_req_t req,
    // Driver controls
    output ppm_pkg::ppm_drv_t      drv
);
    ppm_pkg::ppm_drv_t next_drv;

    always_comb
    begin
        next_drv = '0;
        if (req.dir_out)
        begin
            if (req.od_sel)
            begin
                next_drv.pull_up_on = 1'b0;
                next_drv.pull_dn_on = ~req.out_val;
                next_drv.oe         = ~req.out_val;
            end
            else
            begin
                next_drv.pull_up_on = req.out_val;
                next_drv.pull_dn_on = ~req.out_val;
                next_drv.oe         = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            drv <= '0;
        else
            drv <= next_drv;
    end
endmodule

/* File: verilog/ppm_port_pad_mode_control.sv */
// Port pad mode control: open-drain selects and input thresholds
// Function
// - Open-drain bit 0 (reset value) gives push/pull drive both levels.
// - Open-drain bit 1 selects open-drain driver for that line.
// - In open-drain mode the pull-up transistor is always off.
// - Open-drain with latch 1 floats the pin; external pull-up gives high.
// - One independent open-drain bit per line of ports 2,3,4,6,7,8.
// - Open-drain registers sit at indices 0..5 of the plain register port.
// - Low-byte threshold bit: 0 TTL, 1 hysteresis, pins 7..0.
// - High-byte threshold bit: 0 TTL, 1 hysteresis, pins 15..8.
// - One threshold bit for ports 7 and 8, two for ports 2 and 3.
// - Direction and output mode work whatever threshold is chosen.
`timescale 1ns/10ps
module ppm_port_pad_mode_control
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    // Register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    // Port latches and directions, ports 2,3,4,6,7,8 packed low to high
    input  wire logic [63:0] port_out,
    input  wire logic [63:0] port_dir,
    // Pad driver controls
    output logic      [63:0] pad_pull_up,
    output logic      [63:0] pad_pull_dn,
    output logic      [63:0] pad_oe,
    // Per-pin hysteresis select, same packing
    output logic      [63:0] pad_hyst_sel
);
    localparam int NP = 64;

    // Open-drain selects, one bit per port line
    logic [15:0]               od_port_two;
    logic [15:0]               od_port_three;
    logic [7:0]                od_port_four;
    logic [7:0]                od_port_six;
    logic [7:0]                od_port_seven;
    logic [7:0]                od_port_eight;
    // Byte-wise input threshold selects
    logic [ppm_pkg::THR_W-1:0] thr;
    logic [NP-1:0]             next_hyst;
    logic [15:0]               next_rdata;
    // Per-pin carriers into and out of the pad decoders
    ppm_pkg::ppm_req_t         pad_req [NP];
    ppm_pkg::ppm_drv_t         pad_drv [NP];

    // Write strobe aimed at one register index
    function automatic logic is_wr(input logic [3:0] a);
        is_wr = reg_wr && (reg_addr == a);
    endfunction

    // Byte-wide ports take only the low write byte
    function automatic logic [7:0] low_byte(input logic [15:0] w);
        low_byte = w[7:0];
    endfunction

    // One threshold select spread over the eight pins of its byte
    function automatic logic [7:0] byte_fill(input logic sel);
        byte_fill = {8{sel}};
    endfunction

    // Byte-wide registers read back with a zero upper byte
    function automatic logic [15:0] zext8(input logic [7:0] v);
        zext8 = {8'h00, v};
    endfunction

    // One pin's latch, direction and mode bundled for its decoder
    function automatic ppm_pkg::ppm_req_t make_req(input logic out_val,
                                                   input logic dir_out,
                                                   input logic od_sel);
        make_req         = '0;
        make_req.out_val = out_val;
        make_req.dir_out = dir_out;
        make_req.od_sel  = od_sel;
    endfunction

    // Open-drain selects share the plain register map with the threshold

    // Port two: sixteen independent line selects
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            od_port_two <= ppm_pkg::OD_RST;
        end
        else if (is_wr(ppm_pkg::ADDR_OD_PORT_TWO))
        begin
            od_port_two <= reg_wdata;
        end
    end

    // Port three: sixteen independent line selects
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            od_port_three <= ppm_pkg::OD_RST;
        end
        else if (is_wr(ppm_pkg::ADDR_OD_PORT_THREE))
        begin
            od_port_three <= reg_wdata;
        end
    end

    // Port four: upper write byte is ignored
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            od_port_four <= ppm_pkg::OD_RST[7:0];
        end
        else if (is_wr(ppm_pkg::ADDR_OD_PORT_FOUR))
        begin
            od_port_four <= low_byte(reg_wdata);
        end
    end

    // Port six: upper write byte is ignored
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            od_port_six <= ppm_pkg::OD_RST[7:0];
        end
        else if (is_wr(ppm_pkg::ADDR_OD_PORT_SIX))
        begin
            od_port_six <= low_byte(reg_wdata);
        end
    end

    // Port seven: upper write byte is ignored
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            od_port_seven <= ppm_pkg::OD_RST[7:0];
        end
        else if (is_wr(ppm_pkg::ADDR_OD_PORT_SEVEN))
        begin
            od_port_seven <= low_byte(reg_wdata);
        end
    end

    // Port eight: upper write byte is ignored
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            od_port_eight <= ppm_pkg::OD_RST[7:0];
        end
        else if (is_wr(ppm_pkg::ADDR_OD_PORT_EIGHT))
        begin
            od_port_eight <= low_byte(reg_wdata);
        end
    end

    // Threshold selects come out of reset at TTL levels
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            thr <= ppm_pkg::THR_RST;
        end
        else if (is_wr(ppm_pkg::ADDR_THR))
        begin
            thr <= reg_wdata[ppm_pkg::THR_W-1:0];
        end
    end

    // Byte selects fan out to pins; ports four and six stay TTL
    always_comb
    begin
        next_hyst = '0;
        // Ports two and three have one select per byte
        next_hyst[ppm_pkg::BASE_TWO +: 8] =
            byte_fill(thr[ppm_pkg::THR_P2L]);
        next_hyst[ppm_pkg::BASE_TWO + 8 +: 8] =
            byte_fill(thr[ppm_pkg::THR_P2H]);
        next_hyst[ppm_pkg::BASE_THREE +: 8] =
            byte_fill(thr[ppm_pkg::THR_P3L]);
        next_hyst[ppm_pkg::BASE_THREE + 8 +: 8] =
            byte_fill(thr[ppm_pkg::THR_P3H]);
        // Ports seven and eight have a single select each
        next_hyst[ppm_pkg::BASE_SEVEN +: 8] =
            byte_fill(thr[ppm_pkg::THR_P7L]);
        next_hyst[ppm_pkg::BASE_EIGHT +: 8] =
            byte_fill(thr[ppm_pkg::THR_P8L]);
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pad_hyst_sel <= '0;
        end
        else
        begin
            pad_hyst_sel <= next_hyst;
        end
    end

    // Decoders never see the thresholds, so every mode stays free
    always_comb
    begin
        pad_req = '{default: '0};
        // Port two
        for (int p = 0; p < ppm_pkg::W2; p++)
        begin
            pad_req[ppm_pkg::BASE_TWO + p] =
                make_req(port_out[ppm_pkg::BASE_TWO + p],
                         port_dir[ppm_pkg::BASE_TWO + p],
                         od_port_two[p]);
        end
        // Port three
        for (int p = 0; p < ppm_pkg::W3; p++)
        begin
            pad_req[ppm_pkg::BASE_THREE + p] =
                make_req(port_out[ppm_pkg::BASE_THREE + p],
                         port_dir[ppm_pkg::BASE_THREE + p],
                         od_port_three[p]);
        end
        // Port four
        for (int p = 0; p < ppm_pkg::W4; p++)
        begin
            pad_req[ppm_pkg::BASE_FOUR + p] =
                make_req(port_out[ppm_pkg::BASE_FOUR + p],
                         port_dir[ppm_pkg::BASE_FOUR + p],
                         od_port_four[p]);
        end
        // Port six
        for (int p = 0; p < ppm_pkg::W6; p++)
        begin
            pad_req[ppm_pkg::BASE_SIX + p] =
                make_req(port_out[ppm_pkg::BASE_SIX + p],
                         port_dir[ppm_pkg::BASE_SIX + p],
                         od_port_six[p]);
        end
        // Port seven
        for (int p = 0; p < ppm_pkg::W7; p++)
        begin
            pad_req[ppm_pkg::BASE_SEVEN + p] =
                make_req(port_out[ppm_pkg::BASE_SEVEN + p],
                         port_dir[ppm_pkg::BASE_SEVEN + p],
                         od_port_seven[p]);
        end
        // Port eight
        for (int p = 0; p < ppm_pkg::W8; p++)
        begin
            pad_req[ppm_pkg::BASE_EIGHT + p] =
                make_req(port_out[ppm_pkg::BASE_EIGHT + p],
                         port_dir[ppm_pkg::BASE_EIGHT + p],
                         od_port_eight[p]);
        end
    end

    // A registered decoder per pin keeps pad controls glitch free
    genvar i;
    generate
        for (i = 0; i < NP; i++)
        begin : g_pad
            ppm_pad_ctrl u_pad
            (
                .sys_clk (sys_clk),
                .rstn    (rstn),
                .req     (pad_req[i]),
                .drv     (pad_drv[i])
            );
            assign pad_pull_up[i] = pad_drv[i].pull_up_on;
            assign pad_pull_dn[i] = pad_drv[i].pull_dn_on;
            assign pad_oe[i]      = pad_drv[i].oe;
        end
    endgenerate

    // Unmapped indices read as zero
    always_comb
    begin
        next_rdata = 16'h0000;
        case (reg_addr)
            ppm_pkg::ADDR_OD_PORT_TWO:   next_rdata = od_port_two;
            ppm_pkg::ADDR_OD_PORT_THREE: next_rdata = od_port_three;
            ppm_pkg::ADDR_OD_PORT_FOUR:  next_rdata = zext8(od_port_four);
            ppm_pkg::ADDR_OD_PORT_SIX:   next_rdata = zext8(od_port_six);
            ppm_pkg::ADDR_OD_PORT_SEVEN: next_rdata = zext8(od_port_seven);
            ppm_pkg::ADDR_OD_PORT_EIGHT: next_rdata = zext8(od_port_eight);
            ppm_pkg::ADDR_THR:           next_rdata = {10'h000, thr};
            default:                     next_rdata = 16'h0000;
        endcase
    end

    // Read data clear in any cycle without reg_rd, so stale words never linger
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            reg_rdata <= 16'h0000;
        end
        else if (reg_rd)
        begin
            reg_rdata <= next_rdata;
        end
        else
        begin
            reg_rdata <= 16'h0000;
        end
    end
endmodule

/* File: test/ppm_chk.sv */
// Port-level assertions for the pad mode control block
`timescale 1ns/10ps
module ppm_chk
(
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        rstn,
    // Register port
    input wire logic [3:0]  reg_addr,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    // Pads
    input wire logic [63:0] port_out,
    input wire logic [63:0] port_dir,
    input wire logic [63:0] pad_pull_up,
    input wire logic [63:0] pad_pull_dn,
    input wire logic [63:0] pad_oe,
    input wire logic [63:0] pad_hyst_sel
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    AST_OE_DRIVE:
    assert property (pad_oe == (pad_pull_up | pad_pull_dn))
        else $error("enable disagrees with driven side");
    AST_DIR_OFF:
    assert property (1 |=> ((pad_oe | pad_pull_dn) & ~$past(port_dir)) == 0)
        else $error("input pad is driven");
    AST_PULL_DN:
    assert property (1 |=> pad_pull_dn == ($past(port_dir) & ~$past(port_out)))
        else $error("pull-down wrong");
    AST_PULL_UP:
    assert property (1 |=> (pad_pull_up & ~$past(port_out)) == 0)
        else $error("pull-up on for a low latch");
    AST_RD_IDLE:
    assert property (!reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data outside read slot");
    AST_RD_UNMAPPED:
    assert property (reg_rd && reg_addr > 4'h6 |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    AST_HYST_HOLD:
    assert property (!reg_wr |=> ##1 $stable(pad_hyst_sel))
        else $error("threshold moved without a write");
    AST_HYST_BYTES:
    assert property (pad_hyst_sel == {{8{pad_hyst_sel[56]}},
        {8{pad_hyst_sel[48]}}, 16'h0000, {8{pad_hyst_sel[24]}},
        {8{pad_hyst_sel[16]}}, {8{pad_hyst_sel[8]}}, {8{pad_hyst_sel[0]}}})
        else $error("threshold not per byte");
endmodule

/* File: test/ppm_board.sv */
// Board lines: pull-ups on every pad, lines 0 and 1 tied together
`timescale 1ns/10ps
module ppm_board
(
    // Pad drivers
    input wire logic [63:0] pad_pull_up,
    input wire logic [63:0] pad_pull_dn,
    // Resolved levels
    output logic     [63:0] pin_lvl,
    output logic            wired_and,
    output logic            clash
);
    // A released pad is lifted by its resistor, never left floating
    assign pin_lvl = ~pad_pull_dn;
    assign wired_and = pin_lvl[0] & pin_lvl[1];
    // High driver fighting a low one on the shared wire
    assign clash = (pad_pull_up[0] & pad_pull_dn[1])
                 | (pad_pull_up[1] & pad_pull_dn[0]);
endmodule

/* File: test/testbench.sv */
// Random and corner tests of the pad mode control block
`timescale 1ns/10ps
module testbench;
    logic        sys_clk = 1'b0;
    logic        rstn = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [63:0] port_out = 64'h0, port_dir = 64'h0;
    logic [15:0] reg_rdata;
    logic [63:0] pad_pull_up, pad_pull_dn, pad_oe, pad_hyst_sel, pin_lvl;
    logic        wired_and, clash;
    logic [15:0] od [6] = '{default: 16'h0000};
    logic [5:0]  thr = 6'h00;
    int          num_errors = 0;
    int          compares = 0;
    always #5 sys_clk = ~sys_clk;
    ppm_port_pad_mode_control i_dut (.sys_clk(sys_clk), .rstn(rstn),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .port_out(port_out),
        .port_dir(port_dir), .pad_pull_up(pad_pull_up),
        .pad_pull_dn(pad_pull_dn), .pad_oe(pad_oe),
        .pad_hyst_sel(pad_hyst_sel));
    ppm_board i_board (.pad_pull_up(pad_pull_up), .pad_pull_dn(pad_pull_dn),
        .pin_lvl(pin_lvl), .wired_and(wired_and), .clash(clash));
    task automatic chk(input logic [63:0] g, input logic [63:0] e,
                       input string m);
        compares++;
        if (g !== e)
        begin
            num_errors++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask
    function automatic logic [15:0] exp_rd(input logic [3:0] a);
        if (a < 4'h6)
            return od[a];
        else if (a == 4'h6)
            return {10'h000, thr};
        return 16'h0000;
    endfunction
    function automatic logic [63:0] exp_hyst(input logic [5:0] t);
        return {{8{t[5]}}, {8{t[4]}}, 16'h0000, {8{t[3]}},
                {8{t[2]}}, {8{t[1]}}, {8{t[0]}}};
    endfunction
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        // Byte-wide ports keep only their low byte
        if (a < 4'h6)
            od[a] = (a < 4'h2) ? d : {8'h00, d[7:0]};
        else if (a == 4'h6)
            thr = d[5:0];
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk(64'(reg_rdata), 64'(exp_rd(a)), "read back");
    endtask
    task automatic pads();
        logic [63:0] odl;
        repeat (2) @(posedge sys_clk);
        #1;
        odl = {od[5][7:0], od[4][7:0], od[3][7:0], od[2][7:0], od[1], od[0]};
        chk(pad_pull_up, port_dir & ~odl & port_out, "pull-up");
        chk(pad_pull_dn, port_dir & ~port_out, "pull-down");
        chk(pad_oe, port_dir & (~odl | ~port_out), "enable");
        chk(pin_lvl, ~(port_dir & ~port_out), "line level");
        chk(pad_hyst_sel, exp_hyst(thr), "threshold");
    endtask
    task automatic tally_and_finish();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        void'($urandom(32'h0e7ff043));
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
        for (int a = 0; a < 8; a++)
            rd(4'(a));
        pads();
        $display("test reset done");
        for (int b = 0; b < 6; b++)
        begin
            wr(ppm_pkg::ADDR_THR, 16'(1 << b));
            pads();
        end
        $display("test threshold done");
        for (int i = 0; i < 40; i++)
        begin
            wr(4'($urandom_range(7)), 16'($urandom));
            port_out <= {$urandom, $urandom};
            port_dir <= {$urandom, $urandom};
            pads();
            rd(4'($urandom_range(7)));
        end
        $display("test random done");
        wr(ppm_pkg::ADDR_OD_PORT_TWO, 16'h0003);
        port_dir <= 64'h3;
        for (int v = 0; v < 4; v++)
        begin
            @(posedge sys_clk);
            port_out <= 64'(v);
            pads();
            chk(64'(wired_and), 64'(v == 3), "wired-and");
            chk(64'(clash), 64'h0, "contention");
        end
        $display("test wired-and done");
        tally_and_finish();
    end
endmodule
bind ppm_port_pad_mode_control ppm_chk i_chk (.sys_clk(sys_clk),
    .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .port_out(port_out), .port_dir(port_dir),
    .pad_pull_up(pad_pull_up), .pad_pull_dn(pad_pull_dn), .pad_oe(pad_oe),
    .pad_hyst_sel(pad_hyst_sel));
